// File: aio_complete.sv
/*
 Acknowledge-interrupt completion sequencer: strobes, status capture,
 register store, next fetch request.
 Assumes controllers return status while acknowledged and memory returns
 a data release after the data request.
*/
`timescale 1ns/10ps
`include "aio_defines.svh"
module aio_complete
    import aio_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Instruction context
    input wire logic START,
    input wire logic [`AIO_REG_SEL_W-1:0] TARGET_REG,
    input wire logic [`AIO_WORD_W-1:0] ACCUM_IN,
    input wire logic [`AIO_WORD_W-1:0] NEXT_ADDR_B,
    // Controller link pins
    input wire logic [`AIO_BYTE_W-1:0] CONTROLLER_STATUS_BUS,
    input wire logic FUNCTION_STROBE_ACK,
    input wire logic NOT_ACCEPTED_PRIORITY,
    input wire logic INTERRUPT_CALL_LINE,
    output logic IO_FUNCTION_STROBE,
    output logic IO_CONTROL_STROBE,
    // Memory side
    input wire logic DATA_RELEASE,
    output logic MEMORY_REQUEST,
    output logic DATA_REQUEST,
    output logic CLOCK_INHIBIT,
    output logic [`AIO_PADDR_W-1:0] PROGRAM_ADDR,
    // Status
    output logic INTERRUPT_PENDING,
    output logic SEQUENCE_ACTIVE,
    output logic END_OF_EXECUTION,
    output logic [`AIO_WORD_W-1:0] ACCUM,
    // Register readback
    input wire logic [`AIO_REG_SEL_W-1:0] RD_SEL,
    output logic [`AIO_WORD_W-1:0] RD_DATA
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, change accepted when last two agree
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] pin_q;
    logic [`AIO_BYTE_W-1:0] db1_q;
    logic [`AIO_BYTE_W-1:0] db2_q;
    logic [`AIO_BYTE_W-1:0] db3_q;
    logic [`AIO_BYTE_W-1:0] data_q;

    assign pin_raw = {DATA_RELEASE, INTERRUPT_CALL_LINE, NOT_ACCEPTED_PRIORITY,
                      FUNCTION_STROBE_ACK};

    always_ff @(posedge CLK) begin
        if (RST) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            db1_q <= '0;
            db2_q <= '0;
            db3_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            db1_q <= CONTROLLER_STATUS_BUS;
            db2_q <= db1_q;
            db3_q <= db2_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_filt
            always_ff @(posedge CLK) begin
                if (RST) begin
                    pin_q[g] <= 1'b0;
                end else if (s2_q[g] == s3_q[g]) begin
                    pin_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate

    // Status byte must agree as a whole across two stages before it is taken
    always_ff @(posedge CLK) begin
        if (RST) begin
            data_q <= '0;
        end else if (db2_q == db3_q) begin
            data_q <= db3_q;
        end
    end

    // Filtered pin levels; each lags its pin by three to four clocks
    wire fs_ack = pin_q[0];
    wire not_acc = pin_q[1];
    wire int_call = pin_q[2];
    wire dr_in = pin_q[3];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    phase_e state_q;
    phase_e state_d;
    logic fs_q;
    logic cs_q;
    logic pend_q;
    logic active_q;
    logic mrq_q;
    logic drq_q;
    logic end_of_execution_q;
    logic rw_arm_q;
    logic [`AIO_WORD_W-1:0] acc_q;
    logic [`AIO_PADDR_W-1:0] paddr_q;

    wire in_status = (state_q == ST_STATUS);
    wire in_store = (state_q == ST_STORE);
    wire in_next = (state_q == ST_NEXT);
    wire answered = fs_ack | not_acc;
    wire target_nz = (TARGET_REG != '0);
    wire [`AIO_WORD_W-1:0] sum_status = {data_q, ACCUM_IN[`AIO_WORD_W-`AIO_BYTE_W-1:0]};
    // Sum bus carries the saved address only in the next-instruction phase
    wire [`AIO_WORD_W-1:0] sum_bus = in_next ? NEXT_ADDR_B : acc_q;
    wire release_seen = (state_q == ST_FINAL) && dr_in;

    // Phase order; the final phase holds until the fetched word is released
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (START) state_d = ST_STROBE;
            ST_STROBE: state_d = ST_WAIT;
            ST_WAIT: if (answered) state_d = ST_STATUS;
            ST_STATUS: state_d = ST_STORE;
            ST_STORE: state_d = ST_NEXT;
            ST_NEXT: state_d = ST_FINAL;
            ST_FINAL: if (dr_in) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
            fs_q <= 1'b0;
            cs_q <= 1'b0;
            pend_q <= 1'b0;
            active_q <= 1'b0;
            mrq_q <= 1'b0;
            drq_q <= 1'b0;
            end_of_execution_q <= 1'b0;
            rw_arm_q <= 1'b0;
            acc_q <= '0;
            paddr_q <= '0;
        end else begin
            state_q <= state_d;
            end_of_execution_q <= release_seen;
            if (state_q == ST_IDLE && START) begin
                active_q <= 1'b1;
                cs_q <= 1'b1;
            end else if (release_seen) begin
                active_q <= 1'b0;
            end
            // Strobes stand until the edge that leaves the store subphase
            if (state_q == ST_STROBE) begin
                fs_q <= 1'b1;
            end else if (in_store) begin
                fs_q <= 1'b0;
                cs_q <= 1'b0;
            end
            // Set wins, so a call raised again during the clear keeps the flag up
            if (int_call) begin
                pend_q <= 1'b1;
            end else if (state_q inside {ST_STORE, ST_NEXT, ST_FINAL}) begin
                pend_q <= 1'b0;
            end
            // Register write is armed in the status subphase and spent in the store
            if (in_status) begin
                acc_q <= sum_status;
                rw_arm_q <= target_nz;
            end else if (in_store) begin
                rw_arm_q <= 1'b0;
            end
            // Only the low-order address bits reach the program address register
            if (in_next) begin
                paddr_q <= sum_bus[`AIO_PADDR_W-1:0];
                mrq_q <= 1'b1;
                drq_q <= 1'b1;
            end else if (release_seen) begin
                mrq_q <= 1'b0;
                drq_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // General register write during the store subphase
    gr_write_if grw();
    assign grw.we = in_store & rw_arm_q;
    assign grw.sel = TARGET_REG;
    assign grw.data = sum_bus;

    gen_reg_file #(.DEPTH(`AIO_REG_COUNT)) u_regs (
        .clk(CLK),
        .rst(RST),
        .wr(grw),
        .rd_sel(RD_SEL),
        .rd_data(RD_DATA)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    assign IO_FUNCTION_STROBE = fs_q;
    assign IO_CONTROL_STROBE = cs_q;
    assign MEMORY_REQUEST = mrq_q;
    assign DATA_REQUEST = drq_q;
    // No further processor clock while the instruction fetch is outstanding
    assign CLOCK_INHIBIT = drq_q;
    assign PROGRAM_ADDR = paddr_q;
    assign INTERRUPT_PENDING = pend_q;
    assign SEQUENCE_ACTIVE = active_q;
    assign END_OF_EXECUTION = end_of_execution_q;
    assign ACCUM = acc_q;
endmodule : aio_complete

// File: aio_complete_props.sv
/* Port checker for the acknowledge completion sequencer.
   Assumes one clock, synchronous active-high reset. */
`timescale 1ns/10ps
`include "aio_defines.svh"
module aio_complete_props (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Inputs watched
    input wire logic START,
    input wire logic [`AIO_WORD_W-1:0] ACCUM_IN,
    input wire logic [`AIO_WORD_W-1:0] NEXT_ADDR_B,
    input wire logic [`AIO_BYTE_W-1:0] CONTROLLER_STATUS_BUS,
    input wire logic FUNCTION_STROBE_ACK,
    input wire logic INTERRUPT_CALL_LINE,
    input wire logic DATA_RELEASE,
    // Outputs watched
    input wire logic IO_FUNCTION_STROBE,
    input wire logic IO_CONTROL_STROBE,
    input wire logic MEMORY_REQUEST,
    input wire logic DATA_REQUEST,
    input wire logic CLOCK_INHIBIT,
    input wire logic [`AIO_PADDR_W-1:0] PROGRAM_ADDR,
    input wire logic INTERRUPT_PENDING,
    input wire logic SEQUENCE_ACTIVE,
    input wire logic END_OF_EXECUTION,
    input wire logic [`AIO_WORD_W-1:0] ACCUM
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    rst_clear_a: assert property (disable iff (1'b0)
        RST |=> !IO_FUNCTION_STROBE && !IO_CONTROL_STROBE && !INTERRUPT_PENDING && !SEQUENCE_ACTIVE)
        else $error("reset left sequence state set");
    strobe_start_a: assert property (
        START && !SEQUENCE_ACTIVE |=> IO_CONTROL_STROBE ##1 IO_FUNCTION_STROBE)
        else $error("strobes not raised after start");
    status_capture_a: assert property (
        $changed(ACCUM) && FUNCTION_STROBE_ACK
        |-> ACCUM == {CONTROLLER_STATUS_BUS, $past(ACCUM_IN[23:0])})
        else $error("status byte not in upper accumulator bits");
    strobe_drop_a: assert property (
        $fell(IO_CONTROL_STROBE) |-> $fell(IO_FUNCTION_STROBE) && SEQUENCE_ACTIVE ##1 MEMORY_REQUEST)
        else $error("strobes not dropped together before fetch");
    pending_clear_a: assert property (
        $fell(INTERRUPT_PENDING) |-> $past(SEQUENCE_ACTIVE) && !$past(INTERRUPT_CALL_LINE)
        && !$past(INTERRUPT_CALL_LINE, 2))
        else $error("pending cleared while call active");
    next_fetch_a: assert property (
        $rose(MEMORY_REQUEST) |-> DATA_REQUEST && SEQUENCE_ACTIVE
        && PROGRAM_ADDR == NEXT_ADDR_B[`AIO_PADDR_W-1:0])
        else $error("fetch request or address wrong");
    fetch_hold_a: assert property (
        DATA_REQUEST && !DATA_RELEASE |=> DATA_REQUEST && CLOCK_INHIBIT)
        else $error("data request dropped without release");
    seq_end_a: assert property (
        $fell(SEQUENCE_ACTIVE) |-> END_OF_EXECUTION && !DATA_REQUEST && !MEMORY_REQUEST
        && $past(DATA_RELEASE, 2))
        else $error("sequence ended badly");
    cover property ($rose(IO_FUNCTION_STROBE));
    cover property ($fell(SEQUENCE_ACTIVE));
    cover property ($fell(INTERRUPT_PENDING));
endmodule : aio_complete_props
bind aio_complete aio_complete_props u_aio_complete_props (.CLK, .RST, .START, .ACCUM_IN,
    .NEXT_ADDR_B, .CONTROLLER_STATUS_BUS, .FUNCTION_STROBE_ACK, .INTERRUPT_CALL_LINE,
    .DATA_RELEASE, .IO_FUNCTION_STROBE, .IO_CONTROL_STROBE, .MEMORY_REQUEST, .DATA_REQUEST,
    .CLOCK_INHIBIT, .PROGRAM_ADDR, .INTERRUPT_PENDING, .SEQUENCE_ACTIVE, .END_OF_EXECUTION, .ACCUM);

// File: aio_defines.svh
/*
 Widths, register count and field positions for the acknowledge completion block.
 Assumes inclusion by bare name from any design file.
*/
`ifndef AIO_DEFINES_SVH
`define AIO_DEFINES_SVH
`define AIO_WORD_W 32
`define AIO_BYTE_W 8
`define AIO_REG_SEL_W 4
`define AIO_PADDR_LSB 15
`define AIO_PADDR_W 17
`define AIO_REG_COUNT 16
`endif

// File: aio_pkg.sv
/*
 Types for the acknowledge completion sequencer.
 Assumes the defines header is available.
*/
`include "aio_defines.svh"
package aio_pkg;
    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_STROBE = 7'h02,
        ST_WAIT   = 7'h04,
        ST_STATUS = 7'h08,
        ST_STORE  = 7'h10,
        ST_NEXT   = 7'h20,
        ST_FINAL  = 7'h40
    } phase_e;
    typedef logic [`AIO_WORD_W-1:0] word_t;
endpackage : aio_pkg

// File: controller_model.sv
/* Device controller holding an interrupt, answering the function strobe.
   Assumes strobe from the sequencer, commands from the bench. */
`timescale 1ns/10ps
module controller_model (
    input wire logic clk,
    input wire logic strobe,
    input wire logic refuse,
    input wire logic slow,
    input wire logic raise,
    input wire logic [7:0] status,
    output logic ack,
    output logic nack,
    output logic call,
    output logic [7:0] bus
);
    logic [3:0] wait_q = 4'h0;
    initial {ack, nack, call, bus} = 11'h0;
    always @(posedge clk) begin
        if (raise) call <= 1'b1;
        // Released lines change every cycle
        if (!ack) bus <= ~bus;
        if (!strobe) wait_q <= slow ? 4'h6 : 4'h0;
        if (strobe && !ack && !nack) begin
            if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
            else if (refuse) {nack, call} <= 2'b10;
            else {ack, bus} <= {1'b1, status};
        end else if (!strobe && (ack || nack)) {ack, nack, call} <= 3'b000;
    end
endmodule : controller_model

// File: gen_reg_file.sv
/*
 General register file with registered read data.
 Assumes synchronous reset and single write port.
*/
`timescale 1ns/10ps
`include "aio_defines.svh"
module gen_reg_file
    import aio_pkg::*;
#(
    parameter int DEPTH = `AIO_REG_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write side
    gr_write_if.dst wr,
    // Read side
    input wire logic [`AIO_REG_SEL_W-1:0] rd_sel,
    output logic [`AIO_WORD_W-1:0] rd_data
);
    if (DEPTH != (1 << `AIO_REG_SEL_W)) begin : g_depth_check
        $error("DEPTH must match register select width");
    end

    logic [`AIO_WORD_W-1:0] mem [DEPTH];

    // Words start cleared so an unwritten register reads as zero
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (wr.we) begin
            mem[wr.sel] <= wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_sel];
        end
    end
endmodule : gen_reg_file

// File: gr_write_if.sv
/*
 Write port between the sequencer and the general register file.
 Assumes one clock domain.
*/
`timescale 1ns/10ps
`include "aio_defines.svh"
interface gr_write_if;
    logic we;
    logic [`AIO_REG_SEL_W-1:0] sel;
    logic [`AIO_WORD_W-1:0] data;
    modport src (output we, output sel, output data);
    modport dst (input we, input sel, input data);
endinterface : gr_write_if

// File: io_interrupt_ack_completion_test.sv
/* Self-checking bench for the acknowledge completion sequencer.
   Assumes the controller model and the bound port checker. */
`timescale 1ns/10ps
module io_interrupt_ack_completion_test;
    typedef struct packed {logic [3:0] t; logic [31:0] a; logic [31:0] b; logic [7:0] s;
        logic slow;} row_s;
    row_s rows [3] = '{'{4'h1, 32'h00a5c3e1, 32'h12345678, 8'h81, 1'b0},
        '{4'hf, 32'hffffffff, 32'h0001ffff, 8'h7e, 1'b1},
        '{4'h0, 32'h00000000, 32'hfffe0000, 8'hff, 1'b0}};
    logic CLK = 1'b0, RST = 1'b1, START = 1'b0, rel = 1'b0;
    logic refuse = 1'b0, slow = 1'b0, raise = 1'b0;
    logic [3:0] tgt = 4'h0, rsel = 4'h0;
    logic [31:0] acc_in = 32'h0, nb = 32'h0;
    logic [7:0] stat = 8'h00;
    logic ack, nack, call, fs, cs, memory_request_ff, data_request_ff, pend, act, ci, end_of_execution;
    logic [7:0] bus;
    logic [16:0] paddr;
    logic [31:0] accum, rd;
    int fails = 0, total_checks = 0, cycles = 0, n;
    always #25 CLK = ~CLK;
    aio_complete u_aio_complete (.CLK(CLK), .RST(RST), .START(START), .TARGET_REG(tgt),
        .ACCUM_IN(acc_in), .NEXT_ADDR_B(nb), .CONTROLLER_STATUS_BUS(bus),
        .FUNCTION_STROBE_ACK(ack), .NOT_ACCEPTED_PRIORITY(nack), .INTERRUPT_CALL_LINE(call),
        .IO_FUNCTION_STROBE(fs), .IO_CONTROL_STROBE(cs), .DATA_RELEASE(rel),
        .MEMORY_REQUEST(memory_request_ff), .DATA_REQUEST(data_request_ff), .CLOCK_INHIBIT(ci), .PROGRAM_ADDR(paddr),
        .INTERRUPT_PENDING(pend), .SEQUENCE_ACTIVE(act), .END_OF_EXECUTION(end_of_execution), .ACCUM(accum),
        .RD_SEL(rsel), .RD_DATA(rd));
    controller_model u_controller_model (.clk(CLK), .strobe(fs), .refuse(refuse),
        .slow(slow), .raise(raise), .status(stat), .ack(ack), .nack(nack), .call(call),
        .bus(bus));
    ////////////////////////////////////////////////////////////////////////////////
    task step(input int k);
        repeat (k) @(posedge CLK);
        #2;
    endtask : step
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    task run_seq(input logic [3:0] t, input logic [31:0] a, input logic [31:0] b);
        tgt = t;
        acc_in = a;
        nb = b;
        raise = 1'b1;
        step(1);
        raise = 1'b0;
        step(6);
        check("pending", pend, 1'b1);
        START = 1'b1;
        step(1);
        START = 1'b0;
        for (n = 0; data_request_ff !== 1'b1 && n < 80; n++) step(1);
        check("data request", data_request_ff, 1'b1);
        check("program address", paddr, b[16:0]);
        check("strobes", {fs, cs}, 2'b00);
        check("clock inhibit", ci, 1'b1);
        check("pending held", pend, !refuse);
        step(3);
        rel = 1'b1;
        for (n = 0; act !== 1'b0 && n < 20; n++) step(1);
        check("memory request", {act, memory_request_ff, data_request_ff}, 3'b000);
        check("end of execution", end_of_execution, 1'b1);
        rel = 1'b0;
        step(1);
        check("pending", pend, 1'b0);
    endtask : run_seq
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge CLK) begin
        cycles++;
        if (cycles > 5000) begin
            fails++;
            $display("unexpected timeout expected finish seen hang");
            summarize;
        end
    end
    initial begin
        step(8);
        RST = 1'b0;
        check("idle after reset", {fs, cs, pend, act}, 4'h0);
        $display("reset idle test done");
        for (int i = 0; i < 3; i++) begin
            stat = rows[i].s;
            slow = rows[i].slow;
            run_seq(rows[i].t, rows[i].a, rows[i].b);
            check("accumulator", accum, {rows[i].s, rows[i].a[23:0]});
            rsel = rows[i].t;
            step(1);
            check("register", rd, rows[i].t != 4'h0 ? {rows[i].s, rows[i].a[23:0]} : 32'h0);
            $display("row %0d done", i);
        end
        refuse = 1'b1;
        run_seq(4'h2, 32'h0, 32'h00004321);
        refuse = 1'b0;
        $display("refused function test done");
        raise = 1'b1;
        step(1);
        raise = 1'b0;
        START = 1'b1;
        step(1);
        START = 1'b0;
        step(3);
        RST = 1'b1;
        step(1);
        check("reset mid sequence", {fs, cs, pend, act}, 4'h0);
        RST = 1'b0;
        $display("reset test done");
        summarize;
    end
endmodule : io_interrupt_ack_completion_test
